/* src/ttc_pkg.sv */
/*
 * ttc_pkg: register map, field positions, reset values, source codes and
 * carrier types of the timer trigger control block.
 * Assumes a 16-bit register port whose addresses are byte offsets.
 */
`default_nettype none
package ttc_pkg;

	// register port
	localparam int          ADDR_W = 16;
	localparam int          DATA_W = 16;
	localparam logic [15:0] ADDR_CFG0   = 16'hf410;
	localparam logic [15:0] ADDR_CFG1   = 16'hf412;
	localparam logic [15:0] ADDR_CTRL   = 16'hf414;
	localparam logic [15:0] ADDR_STATUS = 16'hf416;
	localparam logic [15:0] RESET_CFG   = 16'h0000;
	localparam logic [15:0] DATA_ZERO   = 16'h0000;

	// trigger_config_0 fields
	localparam int          CFG0_START_DIS = 0;
	localparam int          CFG0_STOP_EN   = 1;
	localparam int          CFG0_CLEAR     = 2;
	localparam int          CFG0_GATE      = 3;
	localparam int          CFG0_SRC_LO_LSB = 8;
	localparam int          CFG0_SRC_LO_MSB = 11;
	localparam int          CFG0_SRC_HI    = 15;
	localparam logic [15:0] CFG0_MASK      = 16'h8f0f;

	// trigger_config_1 fields
	localparam int          CFG1_EDGE_LSB  = 0;
	localparam int          CFG1_EDGE_MSB  = 1;
	localparam int          CFG1_EMRG_LSB  = 4;
	localparam int          CFG1_EMRG_MSB  = 5;
	localparam logic [15:0] CFG1_MASK      = 16'h0033;

	// control and status fields
	localparam int          CTRL_EMRG_EN   = 0;
	localparam int          STAT_RUNNING   = 0;
	localparam int          STAT_EMRG      = 1;
	localparam int          STAT_READ_SEEN = 2;

	// trigger source codes and groups
	localparam logic [1:0]  SRC_GRP_TERM   = 2'h0;
	localparam logic [1:0]  SRC_GRP_STMR   = 2'h2;
	localparam logic [1:0]  SRC_GRP_CHAN   = 2'h3;
	localparam int          CHAN_CNT       = 4;

	// edge select codes
	localparam logic [1:0]  EDGE_RR        = 2'h0;
	localparam logic [1:0]  EDGE_FR        = 2'h1;
	localparam logic [1:0]  EDGE_RF        = 2'h2;
	localparam logic [1:0]  EDGE_FF        = 2'h3;

	// emergency source codes
	localparam logic [1:0]  EMRG_TERM0     = 2'h0;
	localparam logic [1:0]  EMRG_TERM4     = 2'h1;
	localparam logic [1:0]  EMRG_CMP0      = 2'h2;
	localparam logic [1:0]  EMRG_CMP1      = 2'h3;
	localparam int          TERM_EMRG_A    = 0;
	localparam int          TERM_EMRG_B    = 4;

	// event input vector layout
	localparam int          EV_W           = 22;
	localparam int          EV_TERM        = 0;
	localparam int          EV_STMR        = 8;
	localparam int          EV_CHAN        = 16;
	localparam int          EV_CMP0        = 20;
	localparam int          EV_CMP1        = 21;

	typedef enum logic [1:0] {
		TTC_STOPPED,
		TTC_RUNNING,
		TTC_EMERG
	} ttc_run_e;

	typedef struct packed {
		logic [7:0] terminal_trigger;
		logic [7:0] simple_timer_request;
		logic [3:0] channel_trigger_out;
		logic       comparator0_trigger;
		logic       comparator1_trigger;
	} ttc_events_s;

	typedef struct packed {
		logic start_req;
		logic stop_req;
		logic clear_req;
		logic emerg_stop;
		logic running;
	} ttc_core_req_s;

endpackage
`default_nettype wire

/* src/ttc_trigger_control.sv */
/*
 * ttc_trigger_control: trigger start/stop/clear and emergency stop control
 * for one multi_func_timer channel, with its two trigger configuration
 * registers and a small control/status pair on a plain register port.
 * Assumes event inputs are clocked by ref_clk_i, the counter core acts on
 * one-cycle request pulses and reports reads of counter_value_reg and its
 * own software start/stop as one-cycle pulses.
 * Reserved configuration bits are dropped on write and read as zero.
 */
// Added by the designer: the plain strobed port.
`default_nettype none
module ttc_trigger_control
	import ttc_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 rstn_i,
	// register port
	input  wire logic [ADDR_W-1:0]    reg_addr_i,
	input  wire logic [DATA_W-1:0]    reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output var  logic [DATA_W-1:0]    reg_rdata_o,
	// event sources
	input  wire ttc_pkg::ttc_events_s events_i,
	// counter core side
	input  wire logic                 cnt_read_i,
	input  wire logic                 sw_start_i,
	input  wire logic                 sw_stop_i,
	output var  ttc_pkg::ttc_core_req_s core_o
);
	import ttc_pkg::*;

	typedef struct packed {
		logic [EV_W-1:0]   sync1;
		logic [EV_W-1:0]   sync2;
		logic [EV_W-1:0]   prev;
		logic [DATA_W-1:0] cfg0;
		logic [DATA_W-1:0] cfg1;
		logic              emerg_stop_en;
		ttc_run_e          run;
		logic              read_seen;
		logic [DATA_W-1:0] rdata;
		ttc_core_req_s     req;
	} ttc_state_s;

	ttc_state_s st_r;
	ttc_state_s st_nxt;

	// decoded configuration
	logic       trig_start_dis;
	logic       trig_stop_en;
	logic       clear_on_trig_stop;
	logic       start_gate_on_read;
	logic [4:0] trig_src_sel;
	logic [1:0] trig_edge_sel;
	logic [1:0] emerg_src_sel;

	// event decode
	logic [EV_W-1:0] ev_raw;
	logic [EV_W-1:0] ev_rise;
	logic [EV_W-1:0] ev_fall;
	logic            src_valid;
	logic            src_is_term;
	logic [4:0]      src_index;
	logic            sel_rise;
	logic            sel_fall;
	logic            start_ev;
	logic            stop_ev;
	logic            emerg_ev;
	logic            start_ok;
	logic            gate_open;
	logic            emerg_src_ev;
	logic [DATA_W-1:0] status_word;

	assign trig_start_dis     = st_r.cfg0[CFG0_START_DIS];
	assign trig_stop_en       = st_r.cfg0[CFG0_STOP_EN];
	assign clear_on_trig_stop = st_r.cfg0[CFG0_CLEAR];
	assign start_gate_on_read = st_r.cfg0[CFG0_GATE];
	assign trig_src_sel       = {st_r.cfg0[CFG0_SRC_HI],
	                             st_r.cfg0[CFG0_SRC_LO_MSB:CFG0_SRC_LO_LSB]};
	assign trig_edge_sel      = st_r.cfg1[CFG1_EDGE_MSB:CFG1_EDGE_LSB];
	assign emerg_src_sel      = st_r.cfg1[CFG1_EMRG_MSB:CFG1_EMRG_LSB];

	// simple timer requests and channel outputs alike enter raw and act only through their edges
	assign ev_raw = {events_i.comparator1_trigger,
	                 events_i.comparator0_trigger,
	                 events_i.channel_trigger_out,
	                 events_i.simple_timer_request,
	                 events_i.terminal_trigger};

	assign ev_rise = st_r.sync2 & ~st_r.prev;
	assign ev_fall = ~st_r.sync2 & st_r.prev;

	// map the 5-bit code onto the event vector; reserved codes select nothing
	always_comb begin
		src_valid   = 1'b0;
		src_is_term = 1'b0;
		src_index   = 5'h00;
		case (trig_src_sel[4:3])
			SRC_GRP_TERM: begin
				src_valid   = 1'b1;
				src_is_term = 1'b1;
				src_index   = 5'(EV_TERM) + {2'h0, trig_src_sel[2:0]};
			end
			SRC_GRP_STMR: begin
				src_valid = 1'b1;
				src_index = 5'(EV_STMR) + {2'h0, trig_src_sel[2:0]};
			end
			SRC_GRP_CHAN: begin
				// own channel output is not blocked here; software keeps it out
				src_valid = (trig_src_sel[2:0] < 3'(CHAN_CNT));
				src_index = 5'(EV_CHAN) + {3'h0, trig_src_sel[1:0]};
			end
			// the 01xxx group falls here and selects nothing
			default: begin
				src_valid = 1'b0;
			end
		endcase
	end

	assign sel_rise = src_valid & ev_rise[src_index];
	assign sel_fall = src_valid & ev_fall[src_index];

	// edge select only bites on terminal triggers
	always_comb begin
		start_ev = sel_rise;
		stop_ev  = sel_rise;
		if (src_is_term) begin
			case (trig_edge_sel)
				EDGE_RR: begin
					start_ev = sel_rise;
					stop_ev  = sel_rise;
				end
				EDGE_FR: begin
					start_ev = sel_fall;
					stop_ev  = sel_rise;
				end
				EDGE_RF: begin
					start_ev = sel_rise;
					stop_ev  = sel_fall;
				end
				EDGE_FF: begin
					start_ev = sel_fall;
					stop_ev  = sel_fall;
				end
				default: begin
					start_ev = sel_rise;
					stop_ev  = sel_rise;
				end
			endcase
		end
	end

	// emergency source, rising edges only
	always_comb begin
		case (emerg_src_sel)
			EMRG_TERM0: begin
				emerg_src_ev = ev_rise[EV_TERM + TERM_EMRG_A];
			end
			EMRG_TERM4: begin
				emerg_src_ev = ev_rise[EV_TERM + TERM_EMRG_B];
			end
			EMRG_CMP0: begin
				emerg_src_ev = ev_rise[EV_CMP0];
			end
			EMRG_CMP1: begin
				emerg_src_ev = ev_rise[EV_CMP1];
			end
			default: begin
				emerg_src_ev = 1'b0;
			end
		endcase
	end

	// the enable gates every emergency source alike
	assign emerg_ev = emerg_src_ev & st_r.emerg_stop_en;

	// start permission: enabled, and after a read when gating is on
	// gate opens once counter_value_reg was read after the last stop
	assign gate_open = ~start_gate_on_read | st_r.read_seen;
	assign start_ok  = ~trig_start_dis & gate_open;

	// status view of the run state
	always_comb begin
		status_word                 = DATA_ZERO;
		status_word[STAT_RUNNING]   = (st_r.run == TTC_RUNNING);
		status_word[STAT_EMRG]      = (st_r.run == TTC_EMERG);
		status_word[STAT_READ_SEEN] = st_r.read_seen;
	end

	always_comb begin
		st_nxt = st_r;

		// two-stage synchroniser, then the previous sample
		// only the second stage feeds logic, the first may be metastable
		st_nxt.sync1 = ev_raw;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev  = st_r.sync2;

		// register writes; reserved bits are not stored and read as zero
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_CFG0: begin
					st_nxt.cfg0 = reg_wdata_i & CFG0_MASK;
				end
				ADDR_CFG1: begin
					st_nxt.cfg1 = reg_wdata_i & CFG1_MASK;
				end
				ADDR_CTRL: begin
					st_nxt.emerg_stop_en = reg_wdata_i[CTRL_EMRG_EN];
				end
				default: begin
					st_nxt.emerg_stop_en = st_r.emerg_stop_en;
				end
			endcase
		end

		// read data stand for one cycle only; unmapped reads give zero
		st_nxt.rdata = DATA_ZERO;
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_CFG0: begin
					st_nxt.rdata = st_r.cfg0;
				end
				ADDR_CFG1: begin
					st_nxt.rdata = st_r.cfg1;
				end
				ADDR_CTRL: begin
					st_nxt.rdata = {15'h0000, st_r.emerg_stop_en};
				end
				ADDR_STATUS: begin
					st_nxt.rdata = status_word;
				end
				default: begin
					st_nxt.rdata = DATA_ZERO;
				end
			endcase
		end

		// request pulses default low
		st_nxt.req.start_req  = 1'b0;
		st_nxt.req.stop_req   = 1'b0;
		st_nxt.req.clear_req  = 1'b0;
		st_nxt.req.emerg_stop = 1'b0;

		case (st_r.run)
			TTC_STOPPED: begin
				// an emergency edge while stopped still enters emergency stop
				if (emerg_ev) begin
					st_nxt.run            = TTC_EMERG;
					st_nxt.req.emerg_stop = 1'b1;
				end else if (sw_start_i || (start_ev && start_ok)) begin
					st_nxt.run           = TTC_RUNNING;
					st_nxt.req.start_req = 1'b1;
				end
			end
			TTC_RUNNING: begin
				// emergency outranks trigger stop, which outranks software stop
				if (emerg_ev) begin
					// halt without clearing
					st_nxt.run            = TTC_EMERG;
					st_nxt.req.emerg_stop = 1'b1;
					st_nxt.req.stop_req   = 1'b1;
				end else if (stop_ev && trig_stop_en) begin
					st_nxt.run           = TTC_STOPPED;
					st_nxt.req.stop_req  = 1'b1;
					st_nxt.req.clear_req = clear_on_trig_stop;
				end else if (sw_stop_i) begin
					st_nxt.run          = TTC_STOPPED;
					st_nxt.req.stop_req = 1'b1;
				end
			end
			TTC_EMERG: begin
				// only software leaves emergency stop, never a trigger
				if (sw_start_i) begin
					st_nxt.run           = TTC_RUNNING;
					st_nxt.req.start_req = 1'b1;
				end
			end
			default: begin
				st_nxt.run = TTC_STOPPED;
			end
		endcase

		// read gate: forget old reads on a stop, but a read in that cycle wins
		if (st_nxt.run != TTC_RUNNING && st_r.run == TTC_RUNNING) begin
			st_nxt.read_seen = 1'b0;
		end
		if (cnt_read_i) begin
			st_nxt.read_seen = 1'b1;
		end

		// running follows the next state so it lines up with the pulses
		st_nxt.req.running = (st_nxt.run == TTC_RUNNING);
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// all state zero, the counter core sees no requests
			st_r.sync1         <= '0;
			st_r.sync2         <= '0;
			st_r.prev          <= '0;
			st_r.cfg0          <= RESET_CFG;
			st_r.cfg1          <= RESET_CFG;
			st_r.emerg_stop_en <= 1'b0;
			st_r.run           <= TTC_STOPPED;
			st_r.read_seen     <= 1'b0;
			st_r.rdata         <= DATA_ZERO;
			st_r.req.start_req  <= 1'b0;
			st_r.req.stop_req   <= 1'b0;
			st_r.req.clear_req  <= 1'b0;
			st_r.req.emerg_stop <= 1'b0;
			st_r.req.running    <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs come straight from the state flops
	assign reg_rdata_o = st_r.rdata;
	assign core_o      = st_r.req;

endmodule
`default_nettype wire

/* sim/ttc_assertions.sv */
/*
 * ttc_checker: port assertions of the trigger control block.
 * Assumes it is bound to ttc_trigger_control and sees only its ports.
 */
`default_nettype none
module ttc_checker
	import ttc_pkg::*;
(
	// watched ports
	input wire logic                   ref_clk_i,
	input wire logic                   rstn_i,
	input wire logic [ADDR_W-1:0]      reg_addr_i,
	input wire logic [DATA_W-1:0]      reg_wdata_i,
	input wire logic                   reg_wr_i,
	input wire logic                   reg_rd_i,
	input wire logic [DATA_W-1:0]      reg_rdata_o,
	input wire ttc_pkg::ttc_events_s   events_i,
	input wire logic                   cnt_read_i,
	input wire logic                   sw_start_i,
	input wire logic                   sw_stop_i,
	input wire ttc_pkg::ttc_core_req_s core_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic emerg_r;
	logic en_r;
	// emergency state and enable as seen from the ports
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			emerg_r <= 1'b0;
			en_r    <= 1'b0;
		end else begin
			emerg_r <= core_o.emerg_stop | (emerg_r & ~sw_start_i);
			if (reg_wr_i && reg_addr_i == ADDR_CTRL)
				en_r <= reg_wdata_i[CTRL_EMRG_EN];
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	property p_emerg_keeps;
		core_o.emerg_stop |-> !core_o.clear_req;
	endproperty
	a_emerg_keeps: assert property (p_emerg_keeps)
		else $error("clear with emergency stop");
	property p_clear_on_stop;
		core_o.clear_req |-> core_o.stop_req && !core_o.emerg_stop;
	endproperty
	a_clear_on_stop: assert property (p_clear_on_stop)
		else $error("clear without trigger stop");
	property p_start_runs;
		core_o.start_req |-> core_o.running;
	endproperty
	a_start_runs: assert property (p_start_runs)
		else $error("start without running");
	property p_stop_halts;
		core_o.stop_req |-> !core_o.running;
	endproperty
	a_stop_halts: assert property (p_stop_halts)
		else $error("stop while running");
	property p_emerg_halts;
		core_o.emerg_stop |-> !core_o.running;
	endproperty
	a_emerg_halts: assert property (p_emerg_halts)
		else $error("emergency stop while running");
	property p_no_restart;
		emerg_r |-> !core_o.start_req;
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("trigger start after emergency stop");
	property p_emerg_gated;
		!$past(en_r) |-> !core_o.emerg_stop;
	endproperty
	a_emerg_gated: assert property (p_emerg_gated)
		else $error("emergency stop while disabled");
	property p_start_pulse;
		core_o.start_req |=> !core_o.start_req;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start request longer than one cycle");
endmodule
bind ttc_trigger_control ttc_checker u_ttc_checker (
	.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .events_i(events_i), .cnt_read_i(cnt_read_i),
	.sw_start_i(sw_start_i), .sw_stop_i(sw_stop_i), .core_o(core_o)
);
`default_nettype wire

/* sim/ttc_event_src.sv */
/*
 * ttc_event_src: levels of trigger pins, timer requests, channel outputs
 * and comparator triggers. Assumes one line is set per ref_clk_i cycle.
 */
`default_nettype none
module ttc_event_src
	import ttc_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 rstn_i,
	// line update
	input  wire logic [4:0]           ev_idx_i,
	input  wire logic                 ev_we_i,
	input  wire logic                 ev_lvl_i,
	// event levels
	output var  ttc_pkg::ttc_events_s events_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [EV_W-1:0] lvl_r;
	// raw request levels with no enable in the path
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			lvl_r <= '0;
		else if (ev_we_i)
			lvl_r[ev_idx_i] <= ev_lvl_i;
	end
	assign events_o = '{terminal_trigger: lvl_r[EV_TERM+:8],
		simple_timer_request: lvl_r[EV_STMR+:8], channel_trigger_out: lvl_r[EV_CHAN+:4],
		comparator0_trigger: lvl_r[EV_CMP0], comparator1_trigger: lvl_r[EV_CMP1]};
endmodule
`default_nettype wire

/* sim/ttc_trigger_control_tb.sv */
/*
 * ttc_trigger_control_tb: register, trigger and emergency tests.
 * Assumes the event source model and the bound checker.
 */
`default_nettype none
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin fail_count++; \
	$display("[FAIL] %s exp %h got %h", n, x, g); end end
module ttc_trigger_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ttc_pkg::*;
	localparam int OWN_CH = 3; // arbitrary index of this channel
	logic          ref_clk = 1'b0;
	logic          rstn = 1'b0;
	logic [15:0]   addr = '0;
	logic [15:0]   wdata = '0;
	logic          wr = 1'b0;
	logic          rd = 1'b0;
	logic [4:0]    ev_idx = '0;
	logic          ev_we = 1'b0;
	logic          ev_lvl = 1'b0;
	logic [2:0]    ctl = '0;
	logic [15:0]   rdata;
	ttc_events_s   events;
	ttc_core_req_s core;
	int            fail_count = 0;
	int            check_count = 0;
	int            cyc = 0;
	int            nclr = 0;
	int            nemg = 0;
	logic [3:0]    etab [4] = '{4'b1100, 4'b0101, 4'b1010, 4'b0110};
	int            emg_ev [4] = '{0, 4, 20, 21};
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		nclr += (core.clear_req === 1'b1);
		nemg += (core.emerg_stop === 1'b1);
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	ttc_event_src u_ttc_event_src (.ref_clk_i(ref_clk), .rstn_i(rstn), .ev_idx_i(ev_idx),
		.ev_we_i(ev_we), .ev_lvl_i(ev_lvl), .events_o(events));
	ttc_trigger_control u_ttc_trigger_control (.ref_clk_i(ref_clk), .rstn_i(rstn),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .events_i(events), .cnt_read_i(ctl[2]),
		.sw_start_i(ctl[1]), .sw_stop_i(ctl[0]), .core_o(core));
	task automatic wr16(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd16(input logic [15:0] a, input logic [15:0] x);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", x, rdata)
	endtask
	// set one event line, then compare the running level
	task automatic ev(input int i, input logic l, input logic x);
		@(posedge ref_clk);
		ev_idx <= 5'(i);
		ev_lvl <= l;
		ev_we <= 1'b1;
		@(posedge ref_clk);
		ev_we <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		`CHK("running", x, core.running)
	endtask
	task automatic pulse(input logic [2:0] m);
		@(posedge ref_clk);
		ctl <= m;
		@(posedge ref_clk);
		ctl <= 3'h0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		int c0;
		int n0;
		int i;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		rd16(ADDR_CFG0, RESET_CFG);
		rd16(ADDR_CFG1, RESET_CFG);
		wr16(ADDR_CFG0, 16'hffff);
		rd16(ADDR_CFG0, CFG0_MASK);
		wr16(ADDR_CFG1, 16'hffff);
		rd16(ADDR_CFG1, CFG1_MASK);
		rd16(16'hf4fe, DATA_ZERO);
		$display("test registers done");
		wr16(ADDR_CFG1, DATA_ZERO);
		wr16(ADDR_CFG0, DATA_ZERO);
		ev(0, 1, 1);
		ev(0, 0, 1);
		ev(0, 1, 1);
		ev(0, 0, 1);
		wr16(ADDR_CFG0, 16'h0002);
		ev(0, 1, 0);
		`CHK("clear", 0, nclr)
		ev(0, 0, 0);
		wr16(ADDR_CFG0, 16'h0006);
		ev(0, 1, 1);
		ev(0, 0, 1);
		c0 = nclr;
		ev(0, 1, 0);
		`CHK("clear", c0 + 1, nclr)
		ev(0, 0, 0);
		wr16(ADDR_CFG0, 16'h0003);
		ev(0, 1, 0);
		ev(0, 0, 0);
		wr16(ADDR_CFG0, 16'h000a);
		ev(0, 1, 0);
		ev(0, 0, 0);
		pulse(3'b100);
		ev(0, 1, 1);
		ev(0, 0, 1);
		ev(0, 1, 0);
		ev(0, 0, 0);
		ev(0, 1, 0);
		ev(0, 0, 0);
		$display("test start stop done");
		wr16(ADDR_CFG0, 16'h0002);
		for (int e = 0; e < 4; e++) begin
			wr16(ADDR_CFG1, 16'(e));
			for (int k = 0; k < 4; k++)
				ev(0, !k[0], etab[e][3-k]);
			pulse(3'b001);
		end
		wr16(ADDR_CFG0, 16'h8002);
		ev(8, 1, 1);
		ev(8, 0, 1);
		ev(8, 1, 0);
		ev(8, 0, 0);
		wr16(ADDR_CFG1, DATA_ZERO);
		for (int c = 0; c < 32; c++) begin
			if (c != 24 + OWN_CH) begin
				logic v;
				v = c < 8 || (c >= 16 && c < 28);
				i = c < 16 ? c : c - 8;
				wr16(ADDR_CFG0, {c[4], 3'h0, c[3:0], 8'h02});
				ev(i, 1, v);
				ev(i, 0, v);
				ev(i, 1, 1'b0);
				ev(i, 0, 1'b0);
			end
		end
		$display("test edges and sources done");
		wr16(ADDR_CTRL, 16'h0001);
		wr16(ADDR_CFG0, 16'h8106);
		for (int s = 0; s < 4; s++) begin
			wr16(ADDR_CFG1, 16'(s << 4));
			pulse(3'b010);
			c0 = nclr;
			n0 = nemg;
			ev(emg_ev[s], 1, 0);
			`CHK("emerg", n0 + 1, nemg)
			`CHK("clear", c0, nclr)
			ev(9, 1, 0);
			ev(9, 0, 0);
			ev(emg_ev[s], 0, 0);
		end
		rd16(ADDR_STATUS, 16'h0002);
		wr16(ADDR_CTRL, DATA_ZERO);
		wr16(ADDR_CFG1, DATA_ZERO);
		pulse(3'b010);
		n0 = nemg;
		ev(0, 1, 1);
		ev(0, 0, 1);
		`CHK("emerg", n0, nemg)
		$display("test emergency done");
		end_sim();
	end
endmodule
`default_nettype wire
